// ===== design/rid_consts.vh
// constants for the 14-bit instruction decoder
`ifndef RID_CONSTS_VH
`define RID_CONSTS_VH
`define RID_OSC_PER_CYC 4
`define RID_PH_LAST 2'h3
`define RID_OP_IOR 4'h4
`define RID_OP_AND 4'h5
`define RID_OP_ADD 4'h7
`define RID_OP_CLR 4'h1
`define RID_OP_INC_SKZ 4'hF
`define RID_OP_RRC 4'hC
`define RID_OP_RLC 4'hD
`define RID_BO_CLR 2'h0
`define RID_BO_SET 2'h1
`define RID_BO_SKL 2'h2
`define RID_BO_SKH 2'h3
`define RID_LT_OR 4'h8
`define RID_LT_AND 4'h9
`define RID_LT_XOR 4'hA
`define RID_W_RET 14'h0008
`define RID_W_RETI 14'h0009
`define RID_W_SLEEP 14'h0063
`define RID_W_WDTCLR 14'h0064
`define RID_BIT_D 7
`define RID_BIT_ZERO_FILE_REG 7
`define RID_STK_DEPTH 8
`define RID_TIMER_ADDR 7'h01
`define RID_PCL_ADDR 7'h02
`define RID_PAGE_LO 3
`endif

// ===== design/rid_alu.v
// eight-bit arithmetic unit with carry and digit carry
`timescale 1ns/10ps
`default_nettype none
module rid_alu (
	// operands
	input wire [7:0] opA,
	input wire [7:0] opB,
	input wire subMode,
	// results
	output wire [7:0] sum,
	output wire carry,
	output wire digitCarry
);
	// subtract as a plus not b plus one, carry set means no borrow
	wire [7:0] bEff;
	wire [4:0] lowSum;
	wire [8:0] fullSum;
	assign bEff = subMode ? ~opB : opB;
	assign lowSum = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, subMode};
	assign fullSum = {1'b0, opA} + {1'b0, bEff} + {8'h00, subMode};
	assign sum = fullSum[7:0];
	assign carry = fullSum[8];
	assign digitCarry = lowSum[4];
endmodule // rid_alu
`default_nettype wire

// ===== design/rid_core.v
// instruction decoder and execution control for a 14-bit word core
// Operation
// - add accumulator to file, route, flags
// - and accumulator with file, zero only
// - clear file or accumulator, set zero
// - bit low skips next, second cycle nop
// - bit high skips next instruction
// - pc change or skip costs two cycles
// - port read-modify-write reads pin levels
// - timer write clears assigned prescaler
// - literal minus accumulator, full flags
// - literal and, or, xor into accumulator
// - call pushes, loads page and literal
// - returns pop stack, literal or interrupt
// - sleep word enters standby, flags update
// - increment file, skip when zero
// - or accumulator with file, zero flag
// - rotate through carry, carry only
// - jump loads literal and page bits
// - watchdog clear resets counter, sets flags
// - four clocks per instruction cycle
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rid_consts.vh"
module rid_core (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// program memory
	output reg [12:0] progAddr_r,
	input wire [13:0] progWord,
	// register file
	output reg [6:0] fileAddr_r,
	input wire [7:0] fileRdata,
	input wire fileIsPort,
	input wire [7:0] portPins,
	output reg [7:0] fileWdata_r,
	output reg fileWe_r,
	// page latch and timer side
	input wire [7:0] pageLatch,
	input wire prescOnTimer,
	output reg prescClr_r,
	output reg wdtClr_r,
	output reg standby_r,
	// state visible outside
	output reg [7:0] acc_r,
	output reg carry_r,
	output reg digitCarry_r,
	output reg zero_r,
	output reg timeoutFlag_r,
	output reg powerdownFlag_r,
	output reg intReturn_r,
	output reg [12:0] pc_r
);
	reg [1:0] phase_r;
	reg [13:0] ir_r;
	reg flush_r;
	reg [2:0] sp_r;
	reg [12:0] stack_r [0:`RID_STK_DEPTH-1];
	wire [3:0] op = ir_r[11:8];
	wire [1:0] cls = ir_r[13:12];
	wire dBit = ir_r[`RID_BIT_D];
	wire [7:0] lit = ir_r[7:0];
	wire [2:0] bitSel = ir_r[9:7];
	// port read-modify-write sees the pins, not the latch
	wire [7:0] fVal = fileIsPort ? portPins : fileRdata;
	wire [7:0] aluA;
	wire [7:0] aluB;
	wire aluSub;
	wire [7:0] aluSum;
	wire aluC;
	wire aluDc;
	// literal subtract is the only subtract; byte subtract is not decoded
	assign aluSub = (cls == 2'h3) && (op[3:1] == 3'h6);
	assign aluA = (cls == 2'h3) ? lit : fVal;
	assign aluB = acc_r;
	rid_alu uAlu (
		.opA(aluA),
		.opB(aluB),
		.subMode(aluSub),
		.sum(aluSum),
		.carry(aluC),
		.digitCarry(aluDc)
	);
	wire [7:0] bitMask = 8'h01 << bitSel;
	wire [7:0] incVal = fVal + 8'h01;
	wire [12:0] pcNext = pc_r + 13'h0001;
	// no overflow check: a ninth push silently overwrites the oldest entry
	wire [12:0] stackTop = stack_r[sp_r - 3'h1];
	reg [7:0] res;
	reg toFile;
	reg toAcc;
	reg setZ;
	reg setC;
	reg setDc;
	reg newC;
	reg skip;
	reg jump;
	reg push;
	reg pop;
	reg [12:0] tgt;
	always @* begin
		res = 8'h00;
		toFile = 1'b0;
		toAcc = 1'b0;
		setZ = 1'b0;
		setC = 1'b0;
		setDc = 1'b0;
		newC = carry_r;
		skip = 1'b0;
		jump = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		tgt = {pageLatch[`RID_PAGE_LO+1:`RID_PAGE_LO], ir_r[10:0]};
		case (cls)
		2'h0: begin
			toFile = dBit;
			toAcc = ~dBit;
			case (op)
			`RID_OP_ADD: begin
				res = aluSum;
				setZ = 1'b1;
				setC = 1'b1;
				setDc = 1'b1;
				newC = aluC;
			end
			`RID_OP_AND: begin
				res = acc_r & fVal;
				setZ = 1'b1;
			end
			`RID_OP_IOR: begin
				res = acc_r | fVal;
				setZ = 1'b1;
			end
			`RID_OP_CLR: begin
				res = 8'h00;
				toFile = ir_r[`RID_BIT_ZERO_FILE_REG];
				toAcc = ~ir_r[`RID_BIT_ZERO_FILE_REG];
				setZ = 1'b1;
			end
			`RID_OP_INC_SKZ: begin
				res = incVal;
				skip = (incVal == 8'h00);
			end
			`RID_OP_RLC: begin
				res = {fVal[6:0], carry_r};
				setC = 1'b1;
				newC = fVal[7];
			end
			`RID_OP_RRC: begin
				res = {carry_r, fVal[7:1]};
				setC = 1'b1;
				newC = fVal[0];
			end
			default: begin
				// other byte ops are not decoded here
				toFile = 1'b0;
				toAcc = 1'b0;
				if (ir_r == `RID_W_RET || ir_r == `RID_W_RETI)
					pop = 1'b1;
			end
			endcase
		end
		2'h1: begin
			case (ir_r[11:10])
			`RID_BO_CLR: begin
				res = fVal & ~bitMask;
				toFile = 1'b1;
			end
			`RID_BO_SET: begin
				res = fVal | bitMask;
				toFile = 1'b1;
			end
			`RID_BO_SKL: skip = ~|(fVal & bitMask);
			`RID_BO_SKH: skip = |(fVal & bitMask);
			default: skip = 1'b0;
			endcase
		end
		2'h2: begin
			jump = 1'b1;
			push = ~ir_r[11];
		end
		default: begin
			toAcc = 1'b1;
			if (op[3:2] == 2'h0)
				res = lit;
			else if (op[3:2] == 2'h1) begin
				res = lit;
				pop = 1'b1;
			end else if (op[3:1] == 3'h7 || op[3:1] == 3'h6) begin
				res = aluSum;
				setZ = 1'b1;
				setC = 1'b1;
				setDc = 1'b1;
				newC = aluC;
			end else begin
				setZ = 1'b1;
				case (op)
				`RID_LT_AND: res = acc_r & lit;
				`RID_LT_OR: res = acc_r | lit;
				`RID_LT_XOR: res = acc_r ^ lit;
				default: toAcc = 1'b0;
				endcase
			end
		end
		endcase
	end
	wire writesTimer = toFile && (ir_r[6:0] == `RID_TIMER_ADDR);
	// a pc low write only flushes; the counter itself is not reloaded
	wire writesPcl = toFile && (ir_r[6:0] == `RID_PCL_ADDR);
	integer i;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 2'h0;
			ir_r <= 14'h0000;
			flush_r <= 1'b1;
			sp_r <= 3'h0;
			progAddr_r <= 13'h0000;
			fileAddr_r <= 7'h00;
			fileWdata_r <= 8'h00;
			fileWe_r <= 1'b0;
			prescClr_r <= 1'b0;
			wdtClr_r <= 1'b0;
			standby_r <= 1'b0;
			acc_r <= 8'h00;
			carry_r <= 1'b0;
			digitCarry_r <= 1'b0;
			zero_r <= 1'b0;
			timeoutFlag_r <= 1'b1;
			powerdownFlag_r <= 1'b1;
			intReturn_r <= 1'b0;
			pc_r <= 13'h0000;
			for (i = 0; i < `RID_STK_DEPTH; i = i + 1)
				stack_r[i] <= 13'h0000;
		end else begin
			// one instruction cycle is four clocks
			phase_r <= phase_r + 2'h1;
			fileWe_r <= 1'b0;
			prescClr_r <= 1'b0;
			wdtClr_r <= 1'b0;
			intReturn_r <= 1'b0;
			// held to the next phase 0 so the write pulse still sees it
			if (phase_r == 2'h0)
				fileAddr_r <= ir_r[6:0];
			if (phase_r == `RID_PH_LAST) begin
				// prefetched word becomes next instruction
				ir_r <= progWord;
				progAddr_r <= pcNext;
				pc_r <= pcNext;
				flush_r <= 1'b0;
				// a flushed slot executes as a nop
				// standby only blocks execution; fetch runs on until reset
				if (!flush_r && !standby_r) begin
					if (toFile) begin
						fileWdata_r <= res;
						fileWe_r <= 1'b1;
					end
					if (toAcc)
						acc_r <= res;
					if (setZ)
						zero_r <= (res == 8'h00);
					if (setC)
						carry_r <= newC;
					if (setDc)
						digitCarry_r <= aluDc;
					if (writesTimer && prescOnTimer)
						prescClr_r <= 1'b1;
					if (ir_r == `RID_W_WDTCLR) begin
						wdtClr_r <= 1'b1;
						timeoutFlag_r <= 1'b1;
						powerdownFlag_r <= 1'b1;
					end
					if (ir_r == `RID_W_SLEEP) begin
						standby_r <= 1'b1;
						timeoutFlag_r <= 1'b1;
						powerdownFlag_r <= 1'b0;
					end
					if (skip || jump || pop || writesPcl)
						flush_r <= 1'b1;
					// pc already points past this word: the return address
					if (push) begin
						stack_r[sp_r] <= pc_r;
						sp_r <= sp_r + 3'h1;
					end
					if (jump) begin
						pc_r <= tgt;
						progAddr_r <= tgt;
					end
					if (pop) begin
						pc_r <= stackTop;
						progAddr_r <= stackTop;
						sp_r <= sp_r - 3'h1;
						intReturn_r <= (ir_r == `RID_W_RETI);
					end
				end
			end
		end
	end
endmodule // rid_core
`default_nettype wire

// ===== sim/rid_core_properties.sv
// port assertions for the decoder core
`timescale 1ns/10ps
`default_nettype none
module rid_core_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// watched ports
	input wire logic fileWe_r,
	input wire logic [7:0] acc_r,
	input wire logic wdtClr_r,
	input wire logic standby_r,
	input wire logic prescClr_r,
	input wire logic prescOnTimer,
	input wire logic intReturn_r,
	input wire logic timeoutFlag_r,
	input wire logic powerdownFlag_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	write_gap_a: assert property (fileWe_r |=> !fileWe_r [*3])
		else $error("file writes closer than one cycle");
	acc_gap_a: assert property ($changed(acc_r) |=> $stable(acc_r) [*3])
		else $error("accumulator changed twice in one cycle");
	wdt_flags_a: assert property (wdtClr_r |-> timeoutFlag_r && powerdownFlag_r)
		else $error("watchdog clear left a flag low");
	wdt_pulse_a: assert property (wdtClr_r |=> !wdtClr_r)
		else $error("watchdog clear longer than one clock");
	sleep_flags_a: assert property ($rose(standby_r) |->
		timeoutFlag_r && !powerdownFlag_r)
		else $error("standby entered with wrong flags");
	standby_hold_a: assert property (standby_r |=>
		standby_r && !fileWe_r && $stable(acc_r))
		else $error("activity during standby");
	presc_pulse_a: assert property (prescClr_r |->
		$past(prescOnTimer) ##1 !prescClr_r)
		else $error("bad prescaler clear");
	ret_pulse_a: assert property (intReturn_r |=> !intReturn_r [*3])
		else $error("interrupt return pulse too long");
	cover property (wdtClr_r);
	cover property ($rose(standby_r));
	cover property (intReturn_r);
endmodule // rid_core_props
bind rid_core rid_core_props chk (.*);
`default_nettype wire

// ===== sim/rid_far_mem.sv
// program memory and register file beside the core
`timescale 1ns/10ps
`default_nettype none
module rid_far_mem (
	// clock
	input wire logic clk,
	// program side
	input wire logic [12:0] progAddr_r,
	output logic [13:0] progWord,
	// file side
	input wire logic [6:0] fileAddr_r,
	input wire logic [7:0] fileWdata_r,
	input wire logic fileWe_r,
	output logic [7:0] fileRdata,
	output logic fileIsPort
);
	// image aliases every 16 words so page bits never leave it
	logic [13:0] pm [16];
	logic [7:0] fm [128];
	assign progWord = pm[progAddr_r[3:0]];
	assign fileRdata = fm[fileAddr_r];
	assign fileIsPort = fileAddr_r == 7'h06;
	always @(posedge clk) if (fileWe_r) fm[fileAddr_r] <= fileWdata_r;
endmodule // rid_far_mem
`default_nettype wire

// ===== sim/risc_14bit_instruction_decoder_bench.sv
// self-checking bench for the decoder core
`timescale 1ns/10ps
`default_nettype none
module risc_14bit_instruction_decoder_bench;
	logic clk, rst_n, fileIsPort, prescOnTimer, fileWe_r, prescClr_r;
	logic wdtClr_r, standby_r, carry_r, digitCarry_r, zero_r, intReturn_r;
	logic timeoutFlag_r, powerdownFlag_r;
	logic [12:0] progAddr_r, pc_r;
	logic [13:0] progWord;
	logic [6:0] fileAddr_r;
	logic [7:0] fileRdata, portPins, fileWdata_r, pageLatch, acc_r;
	int err_count, samples_checked, pcl, irc, wdc;
	logic [13:0] p4s [3] = '{14'h0008, 14'h0009, 14'h34A5};
	logic [13:0] tbl [21] = '{14'h0700, 14'h0500, 14'h0400, 14'h0100,
		14'h0F00, 14'h0C00, 14'h0D00, 14'h1000, 14'h1400, 14'h1800, 14'h1C00,
		14'h3000, 14'h3E00, 14'h3900, 14'h3800, 14'h3A00, 14'h3C00, 14'h0064,
		14'h0063, 14'h2803, 14'h2004};
	// pc low, plain, port and timer file addresses
	logic [27:0] fs = {7'h02, 7'h20, 7'h06, 7'h01};
	rid_core dut (.*);
	rid_far_mem far (.*);
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (prescClr_r === 1'b1) pcl++;
		if (intReturn_r === 1'b1) irc++;
		if (wdtClr_r === 1'b1) wdc++;
	end
	task automatic chk(input string nm, input logic [7:0] e, s);
		samples_checked++;
		if (e !== s) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// one program: load, op under test, sentinel bit set, self loop
	task automatic tr(input logic [13:0] base, p4);
		logic [13:0] w;
		logic [8:0] r;
		logic [7:0] a, fv, f, ea, ef, k, pl, pins;
		logic [6:0] fa;
		logic [1:0] cl;
		logic z, c, dc, sk, wr, zu, to, pd, pot, fr;
		cl = base[13:12];
		fr = cl == 1 || (cl == 0 && base[11:8] != 0);
		w = base | ($urandom & (cl == 1 ? 14'h03FF : fr || cl == 3 ? 14'h00FF : 0));
		if (fr) w[6:0] = fs[$urandom % 4 * 7 +: 7];
		fa = fr ? w[6:0] : 7'h20;
		a = $urandom;
		k = w[7:0];
		fv = $urandom % 4 == 0 ? 8'hFF : $urandom;
		pl = $urandom;
		pot = $urandom;
		pins = $urandom;
		f = fa == 7'h06 ? pins : fv;
		ea = a;
		ef = fv;
		{z, c, dc, sk, wr, zu, r} = 0;
		{to, pd} = 2'h3;
		if (cl == 0) begin
			case (w[11:8])
				4'h7: begin r = a + f; c = r[8]; dc = a[3:0] + f[3:0] > 15; zu = 1; end
				4'h5: begin r = a & f; zu = 1; end
				4'h4: begin r = a | f; zu = 1; end
				4'h1: zu = 1;
				4'hF: begin r = f + 1; sk = r[7:0] == 0; end
				4'hC: begin r = f >> 1; c = f[0]; end
				4'hD: begin r = f << 1; c = f[7]; end
				default: begin sk = w == 14'h0063; pd = !sk; end
			endcase
			if (w[11:8] != 0 && w[7]) begin
				wr = 1;
				ef = r[7:0];
			end else if (w[11:8] != 0) ea = r[7:0];
		end else if (cl == 1) begin
			wr = !w[11];
			ef = w[10] ? f | 8'h01 << w[9:7] : f & ~(8'h01 << w[9:7]);
			sk = w[11] && f[w[9:7]] == w[10];
		end else if (cl == 3) begin
			case (w[11:8])
				4'h8: r = a | k;
				4'h9: r = a & k;
				4'hA: r = a ^ k;
				4'hC, 4'hD: begin r = k - a; c = k >= a; dc = k[3:0] >= a[3:0]; end
				4'hE, 4'hF: begin r = a + k; c = r[8]; dc = a[3:0] + k[3:0] > 15; end
				default: r = k;
			endcase
			ea = r[7:0];
			zu = w[11];
		end else begin
			sk = w[11];
			if (!w[11] && p4[13:10] == 4'hD) ea = p4[7:0];
		end
		if (zu) z = r[7:0] == 0;
		if (wr && fa == 7'h02) sk = 1;
		@(posedge clk);
		rst_n <= 0;
		pageLatch <= pl;
		prescOnTimer <= pot;
		portPins <= pins;
		far.pm[0] = {6'h30, a};
		far.pm[1] = w;
		far.pm[2] = 14'h1430;
		far.pm[3] = 14'h2803;
		far.pm[4] = p4;
		far.fm[fa] = fv;
		far.fm[7'h30] = 0;
		pcl = 0;
		irc = 0;
		wdc = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		repeat (48) @(posedge clk);
		@(negedge clk);
		chk("acc", ea, acc_r);
		chk("file", wr ? ef : fv, far.fm[fa]);
		chk("skip", !sk, far.fm[7'h30][0]);
		chk("zero", z, zero_r);
		chk("carry", c, carry_r);
		chk("digit", dc, digitCarry_r);
		chk("flags", {to, pd}, {timeoutFlag_r, powerdownFlag_r});
		if (w != 14'h0063) chk("page", pl[4:3], progAddr_r[12:11]);
		chk("presc", wr && fa == 7'h01 && pot, 8'(pcl));
		chk("iret", p4 == 14'h0009 && w[13:11] == 3'h4, 8'(irc));
		chk("pc", w == 14'h0063 ? 8'h0C : cl == 2 && !w[11] ? 8'h03 : 8'h04,
			pc_r[7:0]);
		if (w != 14'h0063) chk("pc page", pl[4:3], pc_r[12:11]);
		chk("standby", w == 14'h0063, standby_r);
		chk("wdt", w == 14'h0064, 8'(wdc));
	endtask
	initial begin
		rst_n = 0;
		prescOnTimer = 0;
		portPins = 0;
		pageLatch = 0;
		err_count = 0;
		samples_checked = 0;
		for (int i = 0; i < 16; i++) far.pm[i] = 0;
		void'($urandom(28683));
		for (int n = 0; n < 84; n++) tr(tbl[n % 21], p4s[n / 21 % 3]);
		wrap_up;
	end
	initial begin
		#100000;
		err_count++;
		wrap_up;
	end
endmodule // risc_14bit_instruction_decoder_bench
`default_nettype wire
